// ==== plb_port.sv ====
// Purpose: General purpose port with two internal transceiver bits.
// Assumes: One register access per cycle; the core does read-modify-write.
// Notes:   Transceiver bits sit above the six pins.
// Function
// - All pins bidirectional except input-only pin.
// - Output latches hold until rewritten.
// - Direction zero drives, one floats.
// - Transceiver bits reach only the transceiver.
// - Power-on sets analog pins reading zero.
// - Port writes are read then write.
// - Reads return pins, with bit 7 from the transmit latch; writes hit latches.
// - Transmit bit drives, receive bit reflects bus.
// - Transmit zero holds bus dominant.
// - Transceiver bits have fixed direction.
// - Thermal shutdown disables bus driver.
// - Bus activity pin wakes via interrupts.
// - Direction reads: input-only one, transceiver zero.
// - Alternate-function pins read as zero.
`timescale 1ns/1ps
module plb_port (
    // Clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              reset_i,
    input  wire logic              clk_en_i,
    input  wire logic              por_i,
    // Core register access
    input  wire plb_pkg::plb_req_t req_i,
    output logic [7:0]             rdata_o,
    // Configuration from the core
    input  wire logic [5:0]        alt_func_i,
    input  wire logic              sleep_i,
    input  wire logic [1:0]        wake_pin_en_i,
    // Port pins
    input  wire logic [5:0]        pin_i,
    output plb_pkg::plb_pins_t     pins_o,
    // Transceiver
    input  wire logic              bus_receive_i,
    input  wire logic              thermal_shdn_i,
    output logic                   bus_transmit_o,
    output logic                   wake_o
);
    logic [5:0] latch_q;
    logic [1:0] lin_q;
    logic [5:0] dir_q;
    logic [7:0] option_q;
    logic [7:0] status_q;
    logic [5:0] analog_q;
    logic [6:0] sync1_q;
    logic [6:0] sync2_q;
    logic [3:0] prev_q;
    logic [1:0] th_s_q;
    logic [7:0] rd_d;
    logic [7:0] port_view;
    logic       wr_port;
    logic       wr_dir;
    logic       act_d;
    logic [2:0] primed_q;

    localparam logic [5:0] IN_ONLY_MASK = 6'(1 << plb_pkg::IN_ONLY_BIT);

    assign wr_port = req_i.wr && (req_i.addr == plb_pkg::ADDR_PORT);
    assign wr_dir  = req_i.wr && (req_i.addr == plb_pkg::ADDR_DIR);

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
            th_s_q  <= '0;
            primed_q <= '0;
        end else if (clk_en_i) begin
            // Reset zeros in the sync chain would look like a pin edge, so wake waits for real samples.
            primed_q <= {primed_q[1:0], 1'b1};
            sync1_q <= {bus_receive_i, pin_i};
            sync2_q <= sync1_q;
            th_s_q  <= {th_s_q[0], thermal_shdn_i};
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            latch_q <= '0;
            lin_q   <= plb_pkg::LIN_RST;
        end else if (clk_en_i && wr_port) begin
            latch_q <= req_i.wdata[5:0];
            lin_q   <= req_i.wdata[plb_pkg::TX_BIT:plb_pkg::RX_BIT];
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            dir_q <= plb_pkg::DIR_RST;
        end else if (clk_en_i && wr_dir) begin
            dir_q <= req_i.wdata[5:0];
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            analog_q <= plb_pkg::ANALOG_POR;
        end else if (clk_en_i) begin
            if (por_i) begin
                analog_q <= plb_pkg::ANALOG_POR;
            end else if (req_i.wr && req_i.addr == plb_pkg::ADDR_OPTION) begin
                analog_q <= '0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            option_q <= plb_pkg::OPTION_RST;
            status_q <= plb_pkg::STATUS_RST;
        end else if (clk_en_i && req_i.wr) begin
            if (req_i.addr == plb_pkg::ADDR_OPTION) begin
                option_q <= req_i.wdata;
            end
            if (req_i.addr == plb_pkg::ADDR_STATUS) begin
                status_q <= req_i.wdata & plb_pkg::STATUS_WMSK;
            end
        end
    end

    // Alternate and analog pins read zero.
    always_comb begin
        port_view = {lin_q[1], sync2_q[6], sync2_q[5:0] & ~(alt_func_i | analog_q)};
        case (req_i.addr)
            plb_pkg::ADDR_PORT:   rd_d = port_view;
            plb_pkg::ADDR_DIR:    rd_d = {2'h0, dir_q | IN_ONLY_MASK};
            plb_pkg::ADDR_OPTION: rd_d = option_q;
            plb_pkg::ADDR_STATUS: rd_d = status_q;
            default:              rd_d = 8'h00;
        endcase
    end

    always_comb begin
        act_d = sleep_i && primed_q[2] && (wake_pin_en_i[0] ? (sync2_q[2] != prev_q[2])
                : wake_pin_en_i[1] && (sync2_q[3:0] != prev_q));
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o        <= '0;
            pins_o         <= '0;
            bus_transmit_o <= 1'b1;
            wake_o         <= 1'b0;
            prev_q         <= '0;
        end else if (clk_en_i) begin
            rdata_o <= req_i.rd ? rd_d : 8'h00;
            prev_q  <= sync2_q[3:0];
            wake_o  <= act_d;
            pins_o.out <= latch_q;
            pins_o.oe  <= ~dir_q & ~IN_ONLY_MASK;
            bus_transmit_o <= lin_q[1] | th_s_q[1];
        end
    end
endmodule : plb_port

// ==== plb_pkg.sv ====
// Purpose: Shared constants and carriers for the port with transceiver bits.
// Assumes: Register access by address strobes from the core.
// Notes:   Addresses are the core's file addresses.
package plb_pkg;
    localparam logic [7:0] ADDR_STATUS = 8'h03;
    localparam logic [7:0] ADDR_PORT   = 8'h05;
    localparam logic [7:0] ADDR_OPTION = 8'h81;
    localparam logic [7:0] ADDR_DIR    = 8'h85;
    localparam logic [7:0] OPTION_RST  = 8'hff;
    localparam logic [5:0] DIR_RST     = 6'h3f;
    localparam logic [1:0] LIN_RST     = 2'h3;
    localparam logic [5:0] ANALOG_POR  = 6'h17;
    localparam logic [7:0] STATUS_RST  = 8'h18;
    localparam logic [7:0] STATUS_WMSK = 8'h3f;
    localparam int         IN_ONLY_BIT = 3;
    localparam int         TX_BIT      = 7;
    localparam int         RX_BIT      = 6;
    localparam int         NPIN        = 6;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } plb_req_t;

    typedef struct packed {
        logic [5:0] out;
        logic [5:0] oe;
    } plb_pins_t;
endpackage : plb_pkg

// ==== plb_asserts.sv ====
// Purpose: Checker on the port block outputs.
// Assumes: One clock domain.
// Notes:   Bound to plb_port below.
`timescale 1ns/1ps
module plb_asserts (
    input wire logic sys_clk_i, reset_i, clk_en_i, por_i, thermal_shdn_i, bus_transmit_o,
    input wire logic [5:0] alt_func_i,
    input wire logic [7:0] rdata_o,
    input wire plb_pkg::plb_req_t req_i,
    input wire plb_pkg::plb_pins_t pins_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    wire wp = clk_en_i && req_i.wr && req_i.addr == plb_pkg::ADDR_PORT;
    wire wd = clk_en_i && req_i.wr && req_i.addr == plb_pkg::ADDR_DIR;
    wire rq = clk_en_i && req_i.rd;
    oe_pin3_a:
        assert property (!pins_o.oe[3]) else $error("input pin driven");
    dir_oe_a:
        assert property (wd |-> ##2 pins_o.oe[5] != $past(req_i.wdata[5], 2)) else $error("bad enable");
    latch_out_a:
        assert property (wp |-> ##2 pins_o.out[5:4] == $past(req_i.wdata[5:4], 2)) else $error("bad latch");
    latch_hold_a:
        assert property (!$past(wp) && !$past(wp, 2) && !$past(por_i) |-> $stable(pins_o.out)) else $error("latch moved");
    tx_follow_a:
        assert property ((!thermal_shdn_i [*4] ##0 wp) ##1 !thermal_shdn_i |-> ##1
            bus_transmit_o == $past(req_i.wdata[7], 2)) else $error("bad transmit");
    therm_off_a:
        assert property (thermal_shdn_i [*3] |=> bus_transmit_o) else $error("driver on in shutdown");
    dir_read_a:
        assert property (rq && req_i.addr == plb_pkg::ADDR_DIR |=> rdata_o[7:6] == 2'h0 && rdata_o[3])
            else $error("bad direction read");
    alt_zero_a:
        assert property (rq && req_i.addr == plb_pkg::ADDR_PORT |=> (rdata_o[5:0] & $past(alt_func_i)) == 6'h00)
            else $error("alternate pin read");
endmodule : plb_asserts
bind plb_port plb_asserts u_chk (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .por_i(por_i),
    .thermal_shdn_i(thermal_shdn_i), .bus_transmit_o(bus_transmit_o), .alt_func_i(alt_func_i),
    .rdata_o(rdata_o), .req_i(req_i), .pins_o(pins_o));

// ==== plb_pin_model.sv ====
// Purpose: Pins and bus transceiver beyond the port.
// Assumes: Outside drivers yield where the port drives.
// Notes:   No electrical effects.
`timescale 1ns/1ps
module plb_pin_model (
    input  wire plb_pkg::plb_pins_t pins_i,
    input  wire logic [5:0]         ext_i,
    input  wire logic               tx_i,
    input  wire logic               dom_i,
    output logic [5:0]              pin_o,
    output logic                    rx_o
);
    assign pin_o = (pins_i.out & pins_i.oe) | (ext_i & ~pins_i.oe);
    assign rx_o = tx_i & ~dom_i;
endmodule : plb_pin_model

// ==== plb_port_test.sv ====
// Purpose: Self-checking bench of the port.
// Assumes: Inputs move on the falling edge.
// Notes:   Sleep and wake inputs are driven in the wake tests.
`timescale 1ns/1ps
module plb_port_test;
    logic sys_clk_i = 0, reset_i = 1, por = 1, therm = 0, dom = 0, rx, tx;
    logic [5:0] alt = 0, ext = 6'h3f, pin;
    logic en = 1, sleep = 0, seen = 0, wake;
    logic [1:0] wen = 0;
    logic [7:0] rdata, got;
    plb_pkg::plb_req_t req = '0;
    plb_pkg::plb_pins_t pins;
    int failures = 0, tests_run = 0;
    logic [30:0] rows [4] = '{{8'h38, 8'hc5, 7'h54, 8'hed}, {8'h07, 8'h40, 7'h7e, 8'h0f},
        {8'h00, 8'h82, 7'h7e, 8'hca}, {8'h3f, 8'hc0, 7'h2b, 8'h95}};
    initial forever #20 sys_clk_i = ~sys_clk_i;
    plb_port u_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(en), .por_i(por), .req_i(req),
        .rdata_o(rdata), .alt_func_i(alt), .sleep_i(sleep), .wake_pin_en_i(wen), .pin_i(pin), .pins_o(pins),
        .bus_receive_i(rx), .thermal_shdn_i(therm), .bus_transmit_o(tx), .wake_o(wake));
    plb_pin_model u_far (.pins_i(pins), .ext_i(ext), .tx_i(tx), .dom_i(dom), .pin_o(pin), .rx_o(rx));
    task automatic bus(input logic w, input logic [7:0] a, d);
        req = '{w, !w, a, d};
        @(negedge sys_clk_i) got = rdata;
        req = '0;
        @(negedge sys_clk_i);
    endtask : bus
    task automatic chk(input logic [7:0] g, e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: %h %h", $time, g, e);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    initial begin
        repeat (1000) @(posedge sys_clk_i);
        failures++;
        end_sim();
    end
    initial begin
        repeat (6) @(negedge sys_clk_i);
        {reset_i, por} = 2'h0;
        chk({tx, 1'b0, pins.oe}, 8'h80);
        bus(0, plb_pkg::ADDR_DIR, 8'h00);
        chk(got, 8'h3f);
        bus(0, plb_pkg::ADDR_PORT, 8'h00);
        chk(got, 8'he8);
        bus(1, plb_pkg::ADDR_OPTION, 8'hff);
        bus(1, plb_pkg::ADDR_PORT, 8'hc0);
        $display("reset test done");
        foreach (rows[i]) begin
            bus(1, plb_pkg::ADDR_DIR, rows[i][30:23]);
            bus(1, plb_pkg::ADDR_PORT, rows[i][22:15]);
            {ext, dom} = rows[i][14:8];
            repeat (5) @(negedge sys_clk_i);
            bus(0, plb_pkg::ADDR_PORT, 8'h00);
            chk(got, rows[i][7:0]);
            $display("row %0d done", i);
        end
        alt = 6'h03;
        bus(0, plb_pkg::ADDR_PORT, 8'h00);
        chk(got, 8'h94);
        bus(0, 8'h00, 8'h00);
        chk(got, 8'h00);
        bus(1, plb_pkg::ADDR_PORT, 8'h40);
        therm = 1;
        repeat (4) @(negedge sys_clk_i);
        chk({7'h0, tx}, 8'h01);
        $display("edge tests done");
        sleep = 1;
        wen = 2'h1;
        ext = 6'h11;
        repeat (5) @(negedge sys_clk_i) seen |= wake;
        chk({7'h0, seen}, 8'h01);
        {seen, wen} = 3'h2;
        ext = 6'h10;
        repeat (5) @(negedge sys_clk_i) seen |= wake;
        chk({7'h0, seen}, 8'h01);
        {seen, wen} = 3'h0;
        ext = 6'h11;
        repeat (5) @(negedge sys_clk_i) seen |= wake;
        chk({7'h0, seen}, 8'h00);
        sleep = 0;
        en = 0;
        bus(1, plb_pkg::ADDR_DIR, 8'h00);
        en = 1;
        chk({2'h0, pins.oe}, 8'h00);
        ext = 6'h3f;
        por = 1;
        @(negedge sys_clk_i);
        por = 0;
        repeat (3) @(negedge sys_clk_i);
        bus(0, plb_pkg::ADDR_PORT, 8'h00);
        chk(got, 8'h28);
        reset_i = 1;
        @(negedge sys_clk_i);
        reset_i = 0;
        chk({tx, 1'b0, pins.oe}, 8'h80);
        bus(0, plb_pkg::ADDR_DIR, 8'h00);
        chk(got, 8'h3f);
        $display("wake and reset tests done");
        end_sim();
    end
endmodule : plb_port_test
